// ===== common/pfs_pkg.sv
package pfs_pkg;
	// ==========================================================
	// Timing.
	localparam int unsigned CLK_PERIOD_NS = 10;
	// One timer step is 0.1 s, the resolution of every delay setting.
	localparam int unsigned TICK_PERIOD_NS = 100000000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Register word indices; the byte address is four times the index.
	localparam logic [11:0] IDX_LOSS_ACT = 12'hd19;
	localparam logic [11:0] IDX_LOSS_TIME = 12'hd1a;
	localparam logic [11:0] IDX_LOSS_UPPER = 12'hd1b;
	localparam logic [11:0] IDX_LOSS_LOWER = 12'hd1c;
	localparam logic [11:0] IDX_SLEEP_EN = 12'hd1d;
	localparam logic [11:0] IDX_SLEEP_FREQ = 12'hd1e;
	localparam logic [11:0] IDX_SLEEP_DELAY = 12'hd1f;
	localparam logic [11:0] IDX_WAKE_DEV = 12'hd20;
	localparam logic [11:0] IDX_WAKE_DELAY = 12'hd21;
	localparam logic [11:0] IDX_PID_CTRL = 12'hd22;
	localparam logic [11:0] IDX_IRQ_STAT = 12'hd23;
	localparam logic [11:0] IDX_IRQ_CLR = 12'hd24;
	localparam logic [11:0] IDX_IRQ_EN = 12'hd25;
	localparam logic [11:0] IDX_STATE = 12'hd26;

	// ==========================================================
	// Upper bounds of the settings (0.1 %, 0.01 Hz and 0.1 s units).
	localparam logic [15:0] MAX_LOSS_TIME = 16'h04b0;
	localparam logic [15:0] MAX_PERCENT = 16'h03e8;
	localparam logic [15:0] MAX_SLEEP_FREQ = 16'h1388;
	localparam logic [15:0] MAX_SLEEP_DELAY = 16'h8ca0;
	localparam logic [15:0] MAX_WAKE_DEV = 16'h01f4;
	localparam logic [15:0] MAX_WAKE_DELAY = 16'h0258;

	// ==========================================================
	// Interrupt event bit positions.
	localparam int unsigned EV_LOSS = 0;
	localparam int unsigned EV_SLEEP = 1;
	localparam int unsigned EV_WAKE = 2;
	localparam int unsigned EV_W = 3;

	// ==========================================================
	// Types.
	typedef enum logic [1:0] {
		ACT_KEEP = 2'b00,
		ACT_STOP = 2'b01,
		ACT_ALARM = 2'b10,
		ACT_HOLD = 2'b11
	} pfs_act_e;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_JUDGE = 3'b001,
		ST_RAMP = 3'b010,
		ST_SLEEP = 3'b011,
		ST_WAKE = 3'b100
	} pfs_state_e;

	typedef struct packed {
		pfs_act_e act;
		logic [15:0] loss_time;
		logic [15:0] loss_upper;
		logic [15:0] loss_lower;
		logic sleep_en;
		logic [15:0] sleep_freq;
		logic [15:0] sleep_delay;
		logic [15:0] wake_dev;
		logic [15:0] wake_delay;
		logic fb_neg;
	} pfs_cfg_s;

	localparam pfs_cfg_s CFG_RST = '{
		act: ACT_KEEP,
		loss_time: 16'h000a,
		loss_upper: 16'h03e8,
		loss_lower: 16'h0000,
		sleep_en: 1'b0,
		sleep_freq: 16'h03e8,
		sleep_delay: 16'h0258,
		wake_dev: 16'h0032,
		wake_delay: 16'h000a,
		fb_neg: 1'b0
	};
endpackage

// ===== hdl/pfs_supervisor.sv
// Notes on behaviour
// [R1] Loss action 0 keeps running silently; 1 stops, alarms.
// [R2] Action 2 alarms only; 3 holds frequency and alarms.
// [R3] Loss when out of window past detection time.
// [R4] Feedback above upper limit counts toward loss.
// [R5] Feedback below lower limit counts toward loss.
// [R6] Sleep enable setting gates all sleep handling.
// [R7] Judgment starts while PID frequency below sleep frequency.
// [R8] Sleep entered after sleep delay of judgment.
// [R9] Ramp to zero first, then block output.
// [R10] Positive: wake while setpoint minus deviation exceeds feedback.
// [R11] Reverse: wake while setpoint plus deviation exceeds feedback.
// [R12] Wake after condition persists for wake delay.
// [R13] Characteristic bit chooses the wake comparison.
// [R14] Timers restart when their condition drops early.
//
// Added by the designer: register access over APB.
module pfs_supervisor #(
	parameter int unsigned TICK_CYCLES = pfs_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] pid_feedback,
	input wire logic [15:0] pid_setpoint,
	input wire logic [15:0] pid_out_freq,
	input wire logic drive_running,
	input wire logic out_freq_zero,
	output logic loss_alarm,
	output logic loss_stop,
	output logic loss_hold_freq,
	output logic sleep_ramp_down,
	output logic output_block,
	output logic irq
);
	// ==========================================================
	// Register bus.
	pfs_pkg::pfs_cfg_s cfg_r;
	logic [pfs_pkg::EV_W-1:0] stat_r;
	logic [pfs_pkg::EV_W-1:0] irq_en_r;
	logic [pfs_pkg::EV_W-1:0] ev;
	logic [31:0] rd_val;
	logic hit;
	logic setup;
	logic wr;
	logic [11:0] idx;
	logic loss_r;
	logic wake_cond;
	pfs_pkg::pfs_state_e state_r;
	pfs_pkg::pfs_state_e state_nxt;

	assign setup = psel & ~penable;
	assign idx = paddr[13:2];
	assign wr = psel & penable & pready & pwrite & ~pslverr;

	// Limits a written value to the top of its range.
	function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] m);
		lim = (v > m) ? m : v;
	endfunction

	// Decodes the word index into read data and a hit flag.
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0;
		case (idx)
			pfs_pkg::IDX_LOSS_ACT: rd_val[1:0] = cfg_r.act;
			pfs_pkg::IDX_LOSS_TIME: rd_val[15:0] = cfg_r.loss_time;
			pfs_pkg::IDX_LOSS_UPPER: rd_val[15:0] = cfg_r.loss_upper;
			pfs_pkg::IDX_LOSS_LOWER: rd_val[15:0] = cfg_r.loss_lower;
			pfs_pkg::IDX_SLEEP_EN: rd_val[0] = cfg_r.sleep_en;
			pfs_pkg::IDX_SLEEP_FREQ: rd_val[15:0] = cfg_r.sleep_freq;
			pfs_pkg::IDX_SLEEP_DELAY: rd_val[15:0] = cfg_r.sleep_delay;
			pfs_pkg::IDX_WAKE_DEV: rd_val[15:0] = cfg_r.wake_dev;
			pfs_pkg::IDX_WAKE_DELAY: rd_val[15:0] = cfg_r.wake_delay;
			pfs_pkg::IDX_PID_CTRL: rd_val[0] = cfg_r.fb_neg;
			pfs_pkg::IDX_IRQ_STAT: rd_val[pfs_pkg::EV_W-1:0] = stat_r;
			pfs_pkg::IDX_IRQ_CLR: rd_val = 32'h0;
			pfs_pkg::IDX_IRQ_EN: rd_val[pfs_pkg::EV_W-1:0] = irq_en_r;
			pfs_pkg::IDX_STATE: rd_val[4:0] = {wake_cond, loss_r, state_r};
			default: hit = 1'b0;
		endcase
	end

	// Answers every access in its first access cycle; misses raise pslverr.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup) begin
				prdata <= rd_val;
			end
		end
	end

	// Holds the settings; writes are clamped to their documented ranges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= pfs_pkg::CFG_RST;
		end else if (ce && wr) begin
			case (idx)
				pfs_pkg::IDX_LOSS_ACT: cfg_r.act <= pfs_pkg::pfs_act_e'(pwdata[1:0]);
				pfs_pkg::IDX_LOSS_TIME:
					cfg_r.loss_time <= lim(pwdata[15:0], pfs_pkg::MAX_LOSS_TIME);
				pfs_pkg::IDX_LOSS_UPPER:
					cfg_r.loss_upper <= lim(pwdata[15:0], pfs_pkg::MAX_PERCENT);
				pfs_pkg::IDX_LOSS_LOWER:
					cfg_r.loss_lower <= lim(pwdata[15:0], pfs_pkg::MAX_PERCENT);
				pfs_pkg::IDX_SLEEP_EN: cfg_r.sleep_en <= pwdata[0];
				pfs_pkg::IDX_SLEEP_FREQ:
					cfg_r.sleep_freq <= lim(pwdata[15:0], pfs_pkg::MAX_SLEEP_FREQ);
				pfs_pkg::IDX_SLEEP_DELAY:
					cfg_r.sleep_delay <= lim(pwdata[15:0], pfs_pkg::MAX_SLEEP_DELAY);
				pfs_pkg::IDX_WAKE_DEV:
					cfg_r.wake_dev <= lim(pwdata[15:0], pfs_pkg::MAX_WAKE_DEV);
				pfs_pkg::IDX_WAKE_DELAY:
					cfg_r.wake_delay <= lim(pwdata[15:0], pfs_pkg::MAX_WAKE_DELAY);
				pfs_pkg::IDX_PID_CTRL: cfg_r.fb_neg <= pwdata[0]; // [R13]
				default: cfg_r <= cfg_r;
			endcase
		end
	end

	// ==========================================================
	// Time base.
	logic [31:0] tick_cnt_r;
	logic tick_r;

	// Emits one pulse every 0.1 s.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 32'h0;
			tick_r <= 1'b0;
		end else if (ce) begin
			tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
			if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
				tick_cnt_r <= 32'h0;
			end else begin
				tick_cnt_r <= tick_cnt_r + 32'h1;
			end
		end
	end

	// ==========================================================
	// Feedback loss.
	logic out_win;
	logic [15:0] loss_cnt_r;
	logic loss_set;

	assign out_win = (pid_feedback > cfg_r.loss_upper) // [R4]
		| (pid_feedback < cfg_r.loss_lower); // [R5]
	assign loss_set = drive_running & out_win & (loss_cnt_r > cfg_r.loss_time); // [R3]

	// Counts ticks while running outside the window, else restarts.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_cnt_r <= 16'h0;
		end else if (ce) begin
			if (!drive_running || !out_win) begin
				loss_cnt_r <= 16'h0; // [R14]
			end else if (tick_r && loss_cnt_r != 16'hffff) begin
				loss_cnt_r <= loss_cnt_r + 16'h1;
			end
		end
	end

	// Latches loss until the feedback returns into the window.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_r <= 1'b0;
		end else if (ce) begin
			if (!out_win) begin
				loss_r <= 1'b0;
			end else if (loss_set) begin
				loss_r <= 1'b1; // [R3]
			end
		end
	end

	// Maps the chosen action onto the reaction outputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_alarm <= 1'b0;
			loss_stop <= 1'b0;
			loss_hold_freq <= 1'b0;
		end else if (ce) begin
			loss_alarm <= loss_r & (cfg_r.act != pfs_pkg::ACT_KEEP); // [R1] [R2]
			loss_stop <= loss_r & (cfg_r.act == pfs_pkg::ACT_STOP); // [R1]
			loss_hold_freq <= loss_r & (cfg_r.act == pfs_pkg::ACT_HOLD); // [R2]
		end
	end

	// ==========================================================
	// Sleep and wake.
	logic [15:0] tmr_r;
	logic sl_cond;
	logic signed [17:0] wake_ref;

	assign sl_cond = cfg_r.sleep_en & drive_running & (pid_out_freq < cfg_r.sleep_freq); // [R7]
	assign wake_ref = cfg_r.fb_neg
		? $signed({2'b00, pid_setpoint}) + $signed({2'b00, cfg_r.wake_dev}) // [R11]
		: $signed({2'b00, pid_setpoint}) - $signed({2'b00, cfg_r.wake_dev}); // [R10]
	assign wake_cond = wake_ref > $signed({2'b00, pid_feedback}); // [R13]

	// Chooses the next sleep state.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pfs_pkg::ST_RUN: begin
				if (sl_cond) begin
					state_nxt = pfs_pkg::ST_JUDGE; // [R7]
				end
			end
			pfs_pkg::ST_JUDGE: begin
				if (!sl_cond) begin
					state_nxt = pfs_pkg::ST_RUN; // [R14]
				end else if (tmr_r >= cfg_r.sleep_delay) begin
					state_nxt = pfs_pkg::ST_RAMP; // [R8]
				end
			end
			pfs_pkg::ST_RAMP: begin
				if (out_freq_zero) begin
					state_nxt = pfs_pkg::ST_SLEEP; // [R9]
				end
			end
			pfs_pkg::ST_SLEEP: begin
				if (wake_cond) begin
					state_nxt = pfs_pkg::ST_WAKE;
				end
			end
			pfs_pkg::ST_WAKE: begin
				if (!wake_cond) begin
					state_nxt = pfs_pkg::ST_SLEEP; // [R14]
				end else if (tmr_r >= cfg_r.wake_delay) begin
					state_nxt = pfs_pkg::ST_RUN; // [R12]
				end
			end
			default: state_nxt = pfs_pkg::ST_RUN;
		endcase
		if (!cfg_r.sleep_en) begin
			state_nxt = pfs_pkg::ST_RUN; // [R6]
		end
	end

	// Advances the state and its timer, restarting it on every change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= pfs_pkg::ST_RUN;
			tmr_r <= 16'h0;
		end else if (ce) begin
			state_r <= state_nxt;
			if (state_nxt != state_r) begin
				tmr_r <= 16'h0; // [R14]
			end else if (tick_r && tmr_r != 16'hffff) begin
				tmr_r <= tmr_r + 16'h1;
			end
		end
	end

	// Drives the ramp request and the output stage block.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_ramp_down <= 1'b0;
			output_block <= 1'b0;
		end else if (ce) begin
			sleep_ramp_down <= (state_nxt == pfs_pkg::ST_RAMP); // [R9]
			output_block <= (state_nxt == pfs_pkg::ST_SLEEP) || (state_nxt == pfs_pkg::ST_WAKE);
		end
	end

	// ==========================================================
	// Interrupts.
	assign ev[pfs_pkg::EV_LOSS] = loss_set & ~loss_r;
	assign ev[pfs_pkg::EV_SLEEP] = (state_r == pfs_pkg::ST_RAMP) & (state_nxt == pfs_pkg::ST_SLEEP);
	assign ev[pfs_pkg::EV_WAKE] = (state_r == pfs_pkg::ST_WAKE) & (state_nxt == pfs_pkg::ST_RUN);

	// Sticky status; a new event wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
			irq_en_r <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			if (wr && idx == pfs_pkg::IDX_IRQ_CLR) begin
				stat_r <= (stat_r & ~pwdata[pfs_pkg::EV_W-1:0]) | ev;
			end else begin
				stat_r <= stat_r | ev;
			end
			if (wr && idx == pfs_pkg::IDX_IRQ_EN) begin
				irq_en_r <= pwdata[pfs_pkg::EV_W-1:0];
			end
			irq <= |(stat_r & irq_en_r);
		end
	end

	// ==========================================================
	// Checks.
	a_loss_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		ce && cfg_r.act == pfs_pkg::ACT_KEEP |=> !loss_alarm) // [R1]
		else $error("alarm raised under keep action");
	a_loss_stop_map: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		ce && loss_r && cfg_r.act == pfs_pkg::ACT_STOP |=> loss_stop && loss_alarm) // [R1]
		else $error("stop action did not stop and alarm");
	a_loss_hold_map: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		loss_hold_freq |-> $past(cfg_r.act) == pfs_pkg::ACT_HOLD && loss_alarm) // [R2]
		else $error("hold frequency without hold action");
	a_loss_alarm_only: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		ce && loss_r && cfg_r.act == pfs_pkg::ACT_ALARM |=> loss_alarm && !loss_stop) // [R2]
		else $error("alarm action output wrong");
	a_loss_needs_time: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		$rose(loss_r) |-> $past(drive_running && loss_cnt_r > cfg_r.loss_time)) // [R3]
		else $error("loss declared before detection time");
	a_loss_window: assert property (@(posedge pclk) disable iff (!presetn) // [R4] [R5]
		$past(ce) && loss_cnt_r != 16'h0 |-> $past(pid_feedback > cfg_r.loss_upper // [R4]
		|| pid_feedback < cfg_r.loss_lower)) // [R5]
		else $error("loss timer runs inside window");
	a_sleep_off: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		ce && !cfg_r.sleep_en |=> state_r == pfs_pkg::ST_RUN && !output_block) // [R6]
		else $error("sleep active while disabled");
	a_judge_entry: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		state_r == pfs_pkg::ST_JUDGE && $past(state_r) == pfs_pkg::ST_RUN
		|-> $past(pid_out_freq < cfg_r.sleep_freq)) // [R7]
		else $error("judgment began above sleep frequency");
	a_sleep_delay: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		state_r == pfs_pkg::ST_RAMP && $past(state_r) == pfs_pkg::ST_JUDGE
		|-> $past(tmr_r >= cfg_r.sleep_delay)) // [R8]
		else $error("sleep entered before delay");
	a_block_after_ramp: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		$rose(output_block) |-> $past(state_r == pfs_pkg::ST_RAMP && out_freq_zero)) // [R9]
		else $error("output blocked before ramp to zero");
	a_wake_compare: assert property (@(posedge pclk) disable iff (!presetn) // [R10] [R13]
		ce && state_r == pfs_pkg::ST_SLEEP && cfg_r.sleep_en && !cfg_r.fb_neg
		&& $signed({2'b00, pid_setpoint}) - $signed({2'b00, cfg_r.wake_dev})
		> $signed({2'b00, pid_feedback}) |=> state_r == pfs_pkg::ST_WAKE) // [R10] [R13]
		else $error("positive wake comparison ignored");
	a_wake_reverse: assert property (@(posedge pclk) disable iff (!presetn) // [R11] [R13]
		ce && state_r == pfs_pkg::ST_SLEEP && cfg_r.sleep_en && cfg_r.fb_neg
		&& $signed({2'b00, pid_setpoint}) + $signed({2'b00, cfg_r.wake_dev})
		<= $signed({2'b00, pid_feedback}) |=> state_r == pfs_pkg::ST_SLEEP) // [R11] [R13]
		else $error("reverse wake comparison wrong");
	a_wake_delay: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		state_r == pfs_pkg::ST_RUN && $past(state_r) == pfs_pkg::ST_WAKE
		&& $past(cfg_r.sleep_en)
		|-> $past(tmr_r >= cfg_r.wake_delay && wake_cond)) // [R12]
		else $error("woke before wake delay");
	a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		ce && state_nxt != state_r |=> tmr_r == 16'h0) // [R14]
		else $error("timer not restarted");
	a_ramp_request: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		ce && state_nxt == pfs_pkg::ST_RAMP |=> sleep_ramp_down && !output_block)
		else $error("ramp request missing while ramping");
	a_judge_abort: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		ce && state_r == pfs_pkg::ST_JUDGE && !sl_cond |=> state_r == pfs_pkg::ST_RUN)
		else $error("judgment kept after condition dropped");
	a_loss_release: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		ce && !out_win |=> !loss_r)
		else $error("loss flag kept inside window");
	c_loss: cover property (@(posedge pclk) disable iff (!presetn) $rose(loss_stop));
	c_sleep: cover property (@(posedge pclk) disable iff (!presetn) $rose(output_block));
	c_wake: cover property (@(posedge pclk) disable iff (!presetn) ev[pfs_pkg::EV_WAKE]);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	c_reverse_wake: cover property (@(posedge pclk) disable iff (!presetn)
		ev[pfs_pkg::EV_WAKE] && cfg_r.fb_neg);
endmodule

// ===== tb/pfs_plant.sv
// ==========================================================
// Regulator and drive model standing beyond the supervisor.
module pfs_plant #(
	parameter logic [15:0] RAMP_STEP = 16'h0032
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] freq_cmd,
	input wire logic run_cmd,
	input wire logic sleep_ramp_down,
	input wire logic output_block,
	input wire logic loss_stop,
	input wire logic loss_hold_freq,
	output logic [15:0] pid_out_freq,
	output logic drive_running,
	output logic out_freq_zero
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] freq_r;

	// The output frequency follows its command, freezes on hold and ramps down in steps.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_r <= 16'h0000;
		end else if (sleep_ramp_down || output_block) begin
			freq_r <= (freq_r > RAMP_STEP) ? freq_r - RAMP_STEP : 16'h0000;
		end else if (!loss_hold_freq) begin
			freq_r <= freq_cmd;
		end
	end

	// Zero speed is reported whenever the output frequency is zero, also after reset or on a zero command.
	assign pid_out_freq = freq_r;
	assign out_freq_zero = (freq_r == 16'h0000);
	// A stop request from the supervisor halts the drive.
	assign drive_running = run_cmd & ~loss_stop;
endmodule

// ===== tb/tb_top.sv
// ==========================================================
// Self-checking bench for the feedback supervisor.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic wr;
		logic [11:0] idx;
		logic [31:0] wd;
		logic [31:0] ex;
		logic er;
	} pfs_row_s;
	logic pclk, presetn, psel, penable, pwrite, run_cmd, err, pready, pslverr;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] fb_cmd, sp_cmd, freq_cmd, pid_out_freq;
	logic drive_running, out_freq_zero, loss_alarm, loss_stop, loss_hold_freq;
	logic sleep_ramp_down, output_block, irq, ce;
	int err_total, comparisons, n;
	// Reset values first, then clamped writes and refused places.
	pfs_row_s rows [19] = '{
		'{1'b0, 12'hd19, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'hd1a, 32'h0, 32'h000a, 1'b0},
		'{1'b0, 12'hd1b, 32'h0, 32'h03e8, 1'b0},
		'{1'b0, 12'hd1c, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'hd1d, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'hd1e, 32'h0, 32'h03e8, 1'b0},
		'{1'b0, 12'hd1f, 32'h0, 32'h0258, 1'b0},
		'{1'b0, 12'hd20, 32'h0, 32'h0032, 1'b0},
		'{1'b0, 12'hd21, 32'h0, 32'h000a, 1'b0},
		'{1'b1, 12'hd1a, 32'hffff, 32'(pfs_pkg::MAX_LOSS_TIME), 1'b0},
		'{1'b1, 12'hd1b, 32'hffff, 32'(pfs_pkg::MAX_PERCENT), 1'b0},
		'{1'b1, 12'hd1c, 32'hffff, 32'(pfs_pkg::MAX_PERCENT), 1'b0},
		'{1'b1, 12'hd1e, 32'hffff, 32'(pfs_pkg::MAX_SLEEP_FREQ), 1'b0},
		'{1'b1, 12'hd1f, 32'hffff, 32'(pfs_pkg::MAX_SLEEP_DELAY), 1'b0},
		'{1'b1, 12'hd20, 32'hffff, 32'(pfs_pkg::MAX_WAKE_DEV), 1'b0},
		'{1'b1, 12'hd21, 32'hffff, 32'(pfs_pkg::MAX_WAKE_DELAY), 1'b0},
		'{1'b1, 12'hd19, 32'h3, 32'h3, 1'b0},
		'{1'b1, 12'h000, 32'h1234, 32'h0, 1'b1},
		'{1'b0, 12'hd24, 32'h0, 32'h0, 1'b0}
	};

	pfs_supervisor #(.TICK_CYCLES(10)) pfs_supervisor_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pid_feedback(fb_cmd), .pid_setpoint(sp_cmd),
		.pid_out_freq(pid_out_freq), .drive_running(drive_running),
		.out_freq_zero(out_freq_zero), .loss_alarm(loss_alarm), .loss_stop(loss_stop),
		.loss_hold_freq(loss_hold_freq), .sleep_ramp_down(sleep_ramp_down),
		.output_block(output_block), .irq(irq)
	);
	pfs_plant #(.RAMP_STEP(16'h0032)) pfs_plant_inst (
		.pclk(pclk), .presetn(presetn), .freq_cmd(freq_cmd), .run_cmd(run_cmd),
		.sleep_ramp_down(sleep_ramp_down), .output_block(output_block),
		.loss_stop(loss_stop), .loss_hold_freq(loss_hold_freq),
		.pid_out_freq(pid_out_freq), .drive_running(drive_running),
		.out_freq_zero(out_freq_zero)
	);

	// ==========================================================
	// Shared tasks.
	task conclude;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic stall(input string what);
		err_total++;
		$display("mismatch at %0t: %s timed out", $time, what);
		conclude();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) stall("apb");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits for ramp request (0), output block (1) or alarm (2) to reach a level.
	task automatic wait_for(input int which, input logic lvl, input int lim);
		logic v;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			v = (which == 0) ? sleep_ramp_down : (which == 1) ? output_block : loss_alarm;
		end while (v !== lvl && n < lim);
		if (v !== lvl) stall("wait");
	endtask

	// ==========================================================
	// Clock and run limit.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (60000) @(posedge pclk);
		stall("run");
	end

	// ==========================================================
	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 14'h0000;
		pwdata = 32'h0;
		run_cmd = 1'b0;
		ce = 1'b1;
		fb_cmd = 16'h01f4;
		sp_cmd = 16'h01f4;
		freq_cmd = 16'h07d0;
		err_total = 0;
		comparisons = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				apb(1'b1, rows[i].idx, rows[i].wd);
				chk(32'(err), 32'(rows[i].er), "write response");
			end
			apb(1'b0, rows[i].idx, 32'h0);
			chk(rd, rows[i].ex, "read data");
			chk(32'(err), 32'(rows[i].er), "read response");
		end
		// Loss window 0..80 %, two ticks of detection time.
		apb(1'b1, 12'hd1a, 32'h2);
		apb(1'b1, 12'hd1b, 32'h0320);
		apb(1'b1, 12'hd1c, 32'h0);
		apb(1'b1, 12'hd25, 32'h1);
		run_cmd <= 1'b1;
		for (int a = 0; a < 4; a++) begin
			apb(1'b1, 12'hd19, a);
			fb_cmd <= 16'h0384;
			repeat (15) @(posedge pclk);
			chk(32'(loss_alarm), 32'h0, "early loss");
			repeat (40) @(posedge pclk);
			apb(1'b0, 12'hd26, 32'h0);
			chk(32'(rd[3]), 32'h1, "loss flag");
			chk(32'({loss_stop, loss_hold_freq, loss_alarm}), 32'({a == 1, a == 3, a != 0}), "act");
			chk(32'(irq), 32'h1, "loss irq");
			fb_cmd <= 16'h01f4;
			apb(1'b1, 12'hd24, 32'h1);
			apb(1'b0, 12'hd23, 32'h0);
			chk(32'({rd[0], irq}), 32'h0, "irq cleared");
		end
		// A single in-window cycle must restart detection.
		fb_cmd <= 16'h0384;
		repeat (15) @(posedge pclk);
		fb_cmd <= 16'h01f4;
		@(posedge pclk);
		fb_cmd <= 16'h0384;
		repeat (15) @(posedge pclk);
		chk(32'(loss_alarm), 32'h0, "timer restart");
		fb_cmd <= 16'h01f4;
		apb(1'b1, 12'hd25, 32'h0);
		apb(1'b1, 12'hd1c, 32'h00c8);
		fb_cmd <= 16'h0064;
		repeat (55) @(posedge pclk);
		chk(32'(loss_alarm), 32'h1, "below lower");
		chk(32'(irq), 32'h0, "masked irq");
		fb_cmd <= 16'h01f4;
		run_cmd <= 1'b0;
		@(posedge pclk);
		fb_cmd <= 16'h0064;
		repeat (55) @(posedge pclk);
		chk(32'(loss_alarm), 32'h0, "stopped drive");
		run_cmd <= 1'b1;
		fb_cmd <= 16'h01c2;
		// Sleep: 10 Hz threshold, three ticks delay, 5 % deviation, two ticks wake.
		apb(1'b1, 12'hd1e, 32'h03e8);
		apb(1'b1, 12'hd1f, 32'h3);
		apb(1'b1, 12'hd20, 32'h0032);
		apb(1'b1, 12'hd21, 32'h2);
		apb(1'b1, 12'hd24, 32'h7);
		apb(1'b1, 12'hd1d, 32'h1);
		freq_cmd <= 16'h03e8;
		repeat (60) @(posedge pclk);
		chk(32'(sleep_ramp_down), 32'h0, "at threshold");
		apb(1'b1, 12'hd1d, 32'h0);
		freq_cmd <= 16'h01f4;
		repeat (60) @(posedge pclk);
		chk(32'(sleep_ramp_down), 32'h0, "sleep off");
		apb(1'b1, 12'hd1d, 32'h1);
		wait_for(0, 1'b1, 200);
		chk(32'(n >= 20 && n <= 45), 32'h1, "sleep delay");
		chk(32'(output_block), 32'h0, "block early");
		wait_for(1, 1'b1, 100);
		chk(32'(n >= 5), 32'h1, "block after ramp");
		repeat (60) @(posedge pclk);
		chk(32'(output_block), 32'h1, "no wake at edge");
		fb_cmd <= 16'h01c1;
		freq_cmd <= 16'h07d0;
		wait_for(1, 1'b0, 100);
		chk(32'(n >= 10 && n <= 40), 32'h1, "wake delay");
		apb(1'b0, 12'hd23, 32'h0);
		chk(rd, 32'h6, "sleep events");
		// Reverse characteristic compares setpoint plus deviation.
		apb(1'b1, 12'hd22, 32'h1);
		fb_cmd <= 16'h0226;
		freq_cmd <= 16'h01f4;
		wait_for(1, 1'b1, 300);
		repeat (60) @(posedge pclk);
		chk(32'(output_block), 32'h1, "no reverse wake");
		fb_cmd <= 16'h0225;
		freq_cmd <= 16'h07d0;
		wait_for(1, 1'b0, 100);
		// Reset in mid-ramp returns everything to defaults.
		freq_cmd <= 16'h01f4;
		wait_for(0, 1'b1, 200);
		// Clock enable low freezes the ramp state although the drive reaches zero.
		ce <= 1'b0;
		repeat (30) @(posedge pclk);
		chk(32'({sleep_ramp_down, output_block}), 32'h2, "frozen by ce");
		ce <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'({sleep_ramp_down, output_block}), 32'h0, "reset outputs");
		presetn <= 1'b1;
		apb(1'b0, 12'hd1d, 32'h0);
		chk(rd, 32'h0, "enable after reset");
		conclude();
	end
endmodule
